/* File: dv/host_model.sv */
// Purpose: host firmware stand-in that acknowledges suspend notices
// Assumes: notice and acknowledge both run on the core clock
// Notes: the bench sets the reply delay for prompt and slow answers
`timescale 1ns/1ps
module host_model (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic suspend_req_o,
    input wire logic [7:0] delay_i,
    output logic suspend_ack_i = 1'b0
);
    logic [7:0] wait_cnt = 8'h00;
    ////////////////////////////////////////////////////////////////////
    // wait the reply delay, then hold the ack until the notice drops
    always @(negedge core_clk_i) begin
        if (!rst_n_i || suspend_req_o !== 1'b1) begin
            wait_cnt <= 8'h00;
            suspend_ack_i <= 1'b0;
        end else if (wait_cnt >= delay_i) begin
            suspend_ack_i <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 8'h01;
        end
    end
endmodule : host_model

/* File: dv/test_suspend_power_off_sequencer.sv */
// Purpose: self-checking bench for the suspend power-off sequencer
// Assumes: short hold and warning counts, host model acks notices
// Notes: expected events are queued; a monitor matches what appears
`timescale 1ns/1ps
module test_suspend_power_off_sequencer;
    import spo_pkg::*;
    localparam int HOLD = 50;
    localparam int WARN = 200;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic power_switch_i = 1'b0;
    logic reset_switch_i = 1'b0;
    logic key_i = 1'b0;
    logic touch_i = 1'b0;
    logic main_battery_warning_level_i = 1'b0;
    logic main_battery_dead_level_i = 1'b0;
    logic soft_off_req_i = 1'b0;
    logic apo_we_i = 1'b0;
    logic [APO_W-1:0] apo_period_i = 32'h00000000;
    logic resume_i = 1'b0;
    logic suspend_ack_i;
    logic [7:0] ack_delay = 8'h00;
    logic suspend_req_o, save_full_o, save_essential_o, main_power_o;
    logic retain_power_o, buzzer_o, key_enable_o, key_o;
    logic critical_flag_o, maint_boot_o, prev_req;
    logic [CAUSE_W-1:0] suspend_cause_o;
    logic [7:0] notes[$];
    logic [31:0] seed = 32'h00000025;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    int per;
    suspend_power_off_sequencer #(.HOLD_CYCLES(HOLD), .WARN_CYCLES(WARN))
        DUT (.core_clk_i, .rst_n_i, .power_switch_i, .reset_switch_i,
        .key_i, .touch_i, .main_battery_warning_level_i,
        .main_battery_dead_level_i, .soft_off_req_i, .apo_we_i,
        .apo_period_i, .suspend_ack_i, .resume_i, .suspend_req_o,
        .suspend_cause_o, .save_full_o, .save_essential_o, .main_power_o,
        .retain_power_o, .buzzer_o, .key_enable_o, .key_o,
        .critical_flag_o, .maint_boot_o);
    host_model host (.core_clk_i, .rst_n_i, .suspend_req_o,
        .delay_i(ack_delay), .suspend_ack_i);
    ////////////////////////////////////////////////////////////////////
    // clock and cycle ceiling
    initial begin
        forever #4 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            $display("Error %0t run hung", $time);
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic conclude();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    task automatic chk_bit(input logic got, input logic exp, string m);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t %s", $time, m);
        end
    endtask : chk_bit
    task automatic chk_note(input logic [7:0] got);
        checks++;
        if (notes.size() == 0 || got !== notes[0]) begin
            num_errors++;
            $display("Error %0t event %h not expected", $time, got);
        end
        if (notes.size() != 0) begin
            void'(notes.pop_front());
        end
    endtask : chk_note
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : cyc
    task automatic wait_off(input int lim);
        while (main_power_o !== 1'b0 && lim > 0) begin
            cyc(1);
            lim--;
        end
        chk_bit(main_power_o, 1'b0, "power stayed on");
    endtask : wait_off
    task automatic wake();
        resume_i = 1'b1;
        cyc(1);
        resume_i = 1'b0;
        cyc(8);
    endtask : wake
    task automatic soft_off();
        ack_delay = 8'(rnd() % 16);
        notes.push_back({5'h02, CAUSE_SOFT});
        notes.push_back(8'h20);
        soft_off_req_i = 1'b1;
        cyc(1);
        soft_off_req_i = 1'b0;
        wait_off(40);
    endtask : soft_off
    ////////////////////////////////////////////////////////////////////
    // monitor: every event seen is matched to the oldest note
    always @(negedge core_clk_i) begin
        prev_req <= suspend_req_o;
        if (suspend_req_o === 1'b1 && prev_req !== 1'b1) begin
            chk_note({5'h02, suspend_cause_o});
        end
        if (save_full_o === 1'b1) begin
            chk_note(8'h20);
        end
        if (save_essential_o === 1'b1) begin
            chk_note(8'h30);
        end
    end
    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        cyc(16);
        rst_n_i = 1'b1;
        cyc(4);
        power_switch_i = 1'b1;
        key_i = 1'b1;
        cyc(HOLD - 20);
        chk_bit(key_enable_o, 1'b0, "keys not locked");
        chk_bit(key_o, 1'b0, "key passed in lockout");
        power_switch_i = 1'b0;
        key_i = 1'b0;
        cyc(HOLD + 10);
        chk_bit(main_power_o, 1'b1, "short press cut power");
        chk_bit(key_enable_o, 1'b1, "keys still locked");
        key_i = 1'b1;
        cyc(8);
        chk_bit(key_o, 1'b1, "key lost after lockout");
        key_i = 1'b0;
        ack_delay = 8'(rnd() % 16);
        notes.push_back({5'h02, CAUSE_SWITCH});
        notes.push_back(8'h20);
        power_switch_i = 1'b1;
        cyc(HOLD - 5);
        chk_bit(main_power_o, 1'b1, "press off early");
        wait_off(HOLD + 40);
        chk_bit(retain_power_o, 1'b1, "retention lost");
        power_switch_i = 1'b0;
        wake();
        $display("switch test done");
        soft_off();
        wake();
        $display("soft test done");
        per = 80 + int'(rnd() % 64);
        apo_period_i = 32'(per);
        apo_we_i = 1'b1;
        cyc(1);
        apo_we_i = 1'b0;
        cyc(per / 2);
        touch_i = 1'b1;
        cyc(6);
        touch_i = 1'b0;
        cyc(per - 10);
        chk_bit(main_power_o, 1'b1, "idle ignored touch");
        notes.push_back({5'h02, CAUSE_IDLE});
        notes.push_back(8'h20);
        wait_off(60);
        wake();
        apo_period_i = 32'h00000000;
        apo_we_i = 1'b1;
        cyc(1);
        apo_we_i = 1'b0;
        $display("idle test done");
        main_battery_warning_level_i = 1'b1;
        cyc(10);
        chk_bit(buzzer_o, 1'b1, "no alarm");
        cyc(WARN - 70);
        main_battery_warning_level_i = 1'b0;
        cyc(WARN - 60);
        chk_bit(main_power_o, 1'b1, "warn timer kept");
        notes.push_back({5'h02, CAUSE_WARN});
        notes.push_back(8'h20);
        main_battery_warning_level_i = 1'b1;
        cyc(WARN - 20);
        chk_bit(main_power_o, 1'b1, "warn off early");
        wait_off(60);
        main_battery_warning_level_i = 1'b0;
        wake();
        $display("warning test done");
        main_battery_dead_level_i = 1'b1;
        cyc(20);
        chk_bit(main_power_o, 1'b1, "dead without warn");
        notes.push_back(8'h30);
        main_battery_warning_level_i = 1'b1;
        wait_off(20);
        main_battery_dead_level_i = 1'b0;
        main_battery_warning_level_i = 1'b0;
        // let the pin filters settle so the resume sees a healthy battery
        cyc(8);
        wake();
        chk_bit(critical_flag_o, 1'b1, "no critical flag");
        $display("critical test done");
        soft_off();
        reset_switch_i = 1'b1;
        cyc(8);
        reset_switch_i = 1'b0;
        cyc(4);
        chk_bit(retain_power_o, 1'b0, "restart kept power");
        wake();
        chk_bit(maint_boot_o, 1'b1, "no maintenance boot");
        soft_off();
        wake();
        chk_bit(maint_boot_o, 1'b0, "maintenance kept");
        chk_bit(notes.size() == 0, 1'b1, "events missing");
        $display("reset test done");
        conclude();
    end
endmodule : test_suspend_power_off_sequencer

/* File: hdl/pin_sync.sv */
// Purpose: three-flop synchroniser with agreement filter for a pin
// Assumes: pin is asynchronous to core_clk_i
// Notes: first flop is read only by the second
`timescale 1ns/1ps
module pin_sync (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    output logic level_o
);
    logic s1;
    logic s2;
    logic s3;
    // shift chain, then accept a change once stages two and three agree
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level_o <= 1'b0;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level_o <= s3;
            end
        end
    end
endmodule : pin_sync

/* File: hdl/spo_pkg.sv */
// Purpose: constants for the suspend power-off sequencer
// Assumes: core clock of 125 MHz
// Notes: times are kept in their own unit, cycle counts derived
package spo_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned HOLD_MS = 1000;
    localparam int unsigned WARN_MIN = 10;
    // one second rounds down to whole cycles (longest-time rule)
    localparam longint unsigned HOLD_CYC = longint'(CLK_HZ) * HOLD_MS / 1000;
    localparam longint unsigned WARN_CYC = longint'(CLK_HZ) * 60 * WARN_MIN;
    localparam int CNT_W = 40;
    localparam int APO_W = 32;
    localparam int CAUSE_W = 3;
    localparam logic [CAUSE_W-1:0] CAUSE_NONE = 3'h0;
    localparam logic [CAUSE_W-1:0] CAUSE_SWITCH = 3'h1;
    localparam logic [CAUSE_W-1:0] CAUSE_IDLE = 3'h2;
    localparam logic [CAUSE_W-1:0] CAUSE_SOFT = 3'h3;
    localparam logic [CAUSE_W-1:0] CAUSE_WARN = 3'h4;
    localparam logic [CAUSE_W-1:0] CAUSE_DEAD = 3'h5;
    localparam logic [CAUSE_W-1:0] CAUSE_RESET = 3'h6;
    localparam logic [APO_W-1:0] APO_RESET = 32'h0EE6B280;
    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_NOTIFY = 6'h02,
        ST_SAVE = 6'h04,
        ST_CRIT = 6'h08,
        ST_OFF = 6'h10,
        ST_RESTART = 6'h20
    } seq_state_t;
endpackage : spo_pkg

/* File: hdl/suspend_power_off_sequencer.sv */
// Purpose: picks normal or critical suspend from the active off cause
// Assumes: one 125 MHz clock, pins synchronised here, host logic on clock
// Notes: host acknowledges the notice with suspend_ack_i
`timescale 1ns/1ps
module suspend_power_off_sequencer
    import spo_pkg::*;
#(
    parameter longint unsigned HOLD_CYCLES = HOLD_CYC,
    parameter longint unsigned WARN_CYCLES = WARN_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic power_switch_i,
    input wire logic reset_switch_i,
    input wire logic key_i,
    input wire logic touch_i,
    input wire logic main_battery_warning_level_i,
    input wire logic main_battery_dead_level_i,
    input wire logic soft_off_req_i,
    input wire logic apo_we_i,
    input wire logic [APO_W-1:0] apo_period_i,
    input wire logic suspend_ack_i,
    input wire logic resume_i,
    output logic suspend_req_o,
    output logic [CAUSE_W-1:0] suspend_cause_o,
    output logic save_full_o,
    output logic save_essential_o,
    output logic main_power_o,
    output logic retain_power_o,
    output logic buzzer_o,
    output logic key_enable_o,
    output logic key_o,
    output logic critical_flag_o,
    output logic maint_boot_o
);
    ////////////////////////////////////////////////////////////////////
    logic sw;
    logic rst_sw;
    logic key_s;
    logic touch_s;
    logic warn_s;
    logic dead_s;
    logic sw_d;
    seq_state_t state;
    seq_state_t next_state;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] lock_cnt;
    logic [CNT_W-1:0] warn_cnt;
    logic [APO_W-1:0] idle_cnt;
    logic [APO_W-1:0] apo_period;
    logic [CAUSE_W-1:0] cause;
    logic crit_mem;
    logic maint_mem;

    // pin synchronisers
    pin_sync u_sw (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .pin_i(power_switch_i), .level_o(sw));
    pin_sync u_rs (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .pin_i(reset_switch_i), .level_o(rst_sw));
    pin_sync u_key (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .pin_i(key_i), .level_o(key_s));
    pin_sync u_tp (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .pin_i(touch_i), .level_o(touch_s));
    pin_sync u_wl (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .pin_i(main_battery_warning_level_i), .level_o(warn_s));
    pin_sync u_dl (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .pin_i(main_battery_dead_level_i), .level_o(dead_s));

    ////////////////////////////////////////////////////////////////////
    // event decode
    wire running = (state == ST_RUN);
    wire sw_press = sw && !sw_d;
    wire locked = (lock_cnt != '0);
    // a key seen on the very press edge is already inside the lockout
    wire activity = (key_s && !locked && !sw_press) || touch_s;
    // dead only meaningful under the warning level
    wire dead_evt = dead_s && warn_s;
    wire hold_done = (hold_cnt >= CNT_W'(HOLD_CYCLES));
    wire warn_done = (warn_cnt >= CNT_W'(WARN_CYCLES));
    wire idle_done = (apo_period != '0) && (idle_cnt >= apo_period);
    wire [CAUSE_W-1:0] normal_cause =
        hold_done ? CAUSE_SWITCH :
        soft_off_req_i ? CAUSE_SOFT :
        warn_done ? CAUSE_WARN :
        idle_done ? CAUSE_IDLE : CAUSE_NONE;

    // next state; reset switch takes over any state but ST_RESTART, dead battery any but ST_OFF, ST_RESTART and ST_CRIT
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                if (normal_cause != CAUSE_NONE) begin
                    next_state = ST_NOTIFY;
                end
            end
            ST_NOTIFY: begin
                if (suspend_ack_i) begin
                    next_state = ST_SAVE;
                end
            end
            ST_SAVE: next_state = ST_OFF;
            ST_CRIT: next_state = ST_OFF;
            ST_OFF, ST_RESTART: begin
                if (resume_i) begin
                    next_state = ST_RUN;
                end
            end
        endcase
        if (dead_evt && state != ST_OFF && state != ST_RESTART
            && state != ST_CRIT) begin
            next_state = ST_CRIT;
        end
        if (rst_sw && state != ST_RESTART) begin
            next_state = ST_RESTART;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state and cause
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state <= ST_RUN;
            cause <= CAUSE_NONE;
            sw_d <= 1'b0;
        end else begin
            state <= next_state;
            sw_d <= sw;
            if (running && next_state == ST_NOTIFY) begin
                cause <= normal_cause;
            end else if (next_state == ST_CRIT && state != ST_CRIT) begin
                cause <= CAUSE_DEAD;
            end else if (next_state == ST_RESTART) begin
                cause <= CAUSE_RESET;
            end
        end
    end

    // switch hold timer, cleared on release
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !sw || !running) begin
            hold_cnt <= '0;
        end else if (!hold_done) begin
            hold_cnt <= hold_cnt + CNT_W'(1);
        end
    end

    // key lockout after each press
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            lock_cnt <= '0;
        end else if (sw_press) begin
            lock_cnt <= CNT_W'(HOLD_CYCLES);
        end else if (locked) begin
            lock_cnt <= lock_cnt - CNT_W'(1);
        end
    end

    // warning timer, cleared when battery recovers
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !warn_s || !running) begin
            warn_cnt <= '0;
        end else if (!warn_done) begin
            warn_cnt <= warn_cnt + CNT_W'(1);
        end
    end

    // inactivity period setting and idle count
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            apo_period <= APO_RESET;
        end else if (apo_we_i) begin
            apo_period <= apo_period_i;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || activity || !running || apo_we_i) begin
            idle_cnt <= '0;
        end else if (!idle_done) begin
            idle_cnt <= idle_cnt + APO_W'(1);
        end
    end

    // resume indications kept across the off state
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            crit_mem <= 1'b0;
            maint_mem <= 1'b0;
        end else if (state == ST_RUN && next_state != ST_RUN) begin
            crit_mem <= (next_state == ST_CRIT);
            maint_mem <= (next_state == ST_RESTART);
        end else if (state != ST_RUN && next_state != ST_RUN) begin
            if (next_state == ST_RESTART) begin
                maint_mem <= 1'b1;
                crit_mem <= 1'b0;
            end else if (next_state == ST_CRIT) begin
                crit_mem <= 1'b1;
            end
        end
    end

    // registered outputs
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            key_o <= 1'b0;
            suspend_cause_o <= CAUSE_NONE;
        end else begin
            key_o <= key_s && !locked && !sw_press && running;
            suspend_cause_o <= (next_state == ST_NOTIFY) ?
                ((state == ST_RUN) ? normal_cause : cause) : CAUSE_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output decode
    assign suspend_req_o = (state == ST_NOTIFY);
    assign save_full_o = (state == ST_SAVE);
    assign save_essential_o = (state == ST_CRIT);
    assign main_power_o = (state == ST_RUN) || (state == ST_NOTIFY)
        || (state == ST_SAVE);
    assign retain_power_o = (state != ST_RESTART);
    assign buzzer_o = warn_s && running;
    assign key_enable_o = !locked;
    assign critical_flag_o = crit_mem && (state == ST_RUN);
    assign maint_boot_o = maint_mem;

    ////////////////////////////////////////////////////////////////////
    sequence crit_entry_s;
        dead_evt && running;
    endsequence
    sequence crit_path_s;
        save_essential_o ##1 !main_power_o;
    endsequence
    crit_dead_a: assert property (@(posedge core_clk_i) disable iff
        (!rst_n_i) (crit_entry_s and !rst_sw) |=> crit_path_s)
        else $error("dead battery did not force critical suspend");
    crit_silent_a: assert property (@(posedge core_clk_i) disable iff
        (!rst_n_i) crit_entry_s |=> !suspend_req_o)
        else $error("critical suspend was announced");
    notify_first_a: assert property (@(posedge core_clk_i) disable iff
        (!rst_n_i) save_full_o |-> $past(suspend_req_o))
        else $error("save began without notice");
    reset_cut_a: assert property (@(posedge core_clk_i) disable iff
        (!rst_n_i) rst_sw |=> !main_power_o && !retain_power_o)
        else $error("reset switch did not cut power");
    retain_off_a: assert property (@(posedge core_clk_i) disable iff
        (!rst_n_i) state == ST_OFF |-> retain_power_o)
        else $error("retention rail dropped in suspend");
    lock_key_a: assert property (@(posedge core_clk_i) disable iff
        (!rst_n_i) sw_press |=> !key_enable_o [*8])
        else $error("keys accepted during lockout");
    buzz_warn_a: assert property (@(posedge core_clk_i) disable iff
        (!rst_n_i) running && warn_s |-> buzzer_o)
        else $error("buzzer silent on low battery");
    hold_clear_a: assert property (@(posedge core_clk_i) disable iff
        (!rst_n_i) !sw |=> hold_cnt == '0)
        else $error("hold timer kept counting after release");
    hold_short_a: assert property (@(posedge core_clk_i) disable iff
        (!rst_n_i) running && normal_cause == CAUSE_SWITCH
        |-> hold_cnt >= CNT_W'(HOLD_CYCLES))
        else $error("switch suspend before hold time");
    apo_write_a: assert property (@(posedge core_clk_i) disable iff
        (!rst_n_i) apo_we_i |=> apo_period == $past(apo_period_i))
        else $error("inactivity period not updated");
endmodule : suspend_power_off_sequencer
